// [design/priority_interrupt_unit_pkg.sv]
// Constants, types and helper functions of the eight-level priority interrupt unit.
// Assumes a single 50 MHz clock domain and an 8-bit register port.
package priority_interrupt_unit_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int LEVELS = 8;
    localparam int NUM_SRC = 26;
    localparam int SRC_SEL_W = 5;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int EV_W = 3;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_MASK = 4'h1;
    localparam logic [3:0] REG_BASE_LO = 4'h2;
    localparam logic [3:0] REG_BASE_HI = 4'h3;
    localparam logic [3:0] REG_REQ = 4'h4;
    localparam logic [3:0] REG_INSERV = 4'h5;
    localparam logic [3:0] REG_POLL = 4'h6;
    localparam logic [3:0] REG_EOI = 4'h7;
    localparam logic [3:0] REG_EV_STAT = 4'h8;
    localparam logic [3:0] REG_EV_MASK = 4'h9;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SPACING_BIT = 2;
    localparam int CTRL_LOW_LSB = 4;
    localparam int POLL_VALID_BIT = 7;
    localparam int EV_VECTOR = 0;
    localparam int EV_SPURIOUS = 1;
    localparam int EV_POWER = 2;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] BASE_RST = 8'h00;
    localparam logic [2:0] LOWEST_RST = 3'h7;
    localparam logic [2:0] NESTED_LOWEST = 3'h7;
    localparam logic [2:0] EV_RST = 3'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_NESTED = 2'b00,
        MODE_AUTO = 2'b01,
        MODE_SPECIFIC = 2'b10,
        MODE_POLLED = 2'b11
    } mode_t;

    typedef struct packed {
        logic [8:0] bus;
        logic [7:0] direct;
        logic [1:0] timer;
        logic ser_tx_empty;
        logic ser_rx_ready;
        logic [3:0] par;
    } src_lines_t;

    typedef logic [LEVELS-1:0][SRC_SEL_W-1:0] route_map_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } vec_out_t;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Rank 0 is highest; the level just after the lowest one wins
    function automatic logic [2:0] level_rank(input logic [2:0] level, input logic [2:0] lowest);
        level_rank = 3'(level - lowest - 3'h1);
    endfunction

    // Table start keeps base bits above the table size, level scaled by spacing
    function automatic logic [15:0] vector_of(input logic [15:0] base, input logic [2:0] level,
                                              input logic spacing8);
        if (spacing8)
            vector_of = {base[15:6], level, 3'h0};
        else
            vector_of = {base[15:5], level, 2'h0};
    endfunction

endpackage

// [design/priority_resolver.sv]
// Combinational picker of the best-ranked set bit among eight levels.
// Assumes the caller supplies the current lowest-priority level.
`timescale 1ns/1ps

module priority_resolver
    import priority_interrupt_unit_pkg::*;
(
    input wire logic [LEVELS-1:0] vec,
    input wire logic [2:0] lowest,
    output logic found,
    output logic [2:0] level,
    output logic [2:0] rank
);

    // ------------------------------------------------------------
    // Search
    // ------------------------------------------------------------
    // Plain loop; eight levels keep the comparator chain short
    always_comb
    begin
        found = 1'b0;
        level = 3'h0;
        rank = 3'h7;
        for (int i = 0; i < LEVELS; i++)
        begin
            if (vec[i] && (!found || level_rank(3'(i), lowest) < rank))
            begin
                found = 1'b1;
                level = 3'(i);
                rank = level_rank(3'(i), lowest);
            end
        end
    end

endmodule

// [design/priority_interrupt_unit.sv]
// Eight-level vectored priority interrupt unit with register port and event interrupt.
// Assumes inputs synchronous to clk, one-cycle strobes and a one-cycle acknowledge pulse.
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps

// Functional notes
// [R1] Eight request levels, each with own vector
// [R2] Four modes, reprogrammable anytime without reset
// [R3] Interrupt only when pending outranks in-service
// [R4] Software mask byte, one bit per level
// [R5] Nested mode: level 0 highest, 7 lowest
// [R6] Auto mode: serviced level becomes lowest
// [R7] Specific mode: software names lowest level
// [R8] Polled mode: status read, no CPU interrupt
// [R9] Vector spacing of four or eight bytes
// [R10] Table relocatable on its own size boundary
// [R11] Four parallel port requests, jumper routed
// [R12] Two serial requests: receive ready, transmit empty
// [R13] Each timer drives one routed request
// [R14] Bus and direct peripheral lines drive requests
// [R15] Mains low warning raises power-fail request
// [R16] Acknowledge gives vector, marks in service
module priority_interrupt_unit
    import priority_interrupt_unit_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    input wire src_lines_t src,
    input wire logic mains_low_warning,
    input wire route_map_t jumper_sel,
    input wire logic inta,
    output logic cpu_int,
    output vec_out_t vector,
    output logic event_irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] mask_q, mask_d;
    logic [7:0] base_lo_q, base_lo_d;
    logic [7:0] base_hi_q, base_hi_d;
    logic [LEVELS-1:0] req_q, req_d;
    logic [LEVELS-1:0] inserv_q, inserv_d;
    logic [LEVELS-1:0] line_q;
    logic [2:0] rot_low_q, rot_low_d;
    logic [EV_W-1:0] ev_stat_q, ev_stat_d;
    logic [EV_W-1:0] ev_mask_q, ev_mask_d;
    logic pf_q;
    logic cpu_int_q, cpu_int_d;
    vec_out_t vec_q, vec_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;

    // ------------------------------------------------------------
    // Request routing
    // ------------------------------------------------------------
    logic [31:0] src_vec;
    logic [LEVELS-1:0] line;
    mode_t mode;
    logic spacing8;
    logic [2:0] lowest;
    logic [15:0] base;

    // Unused selector codes route nothing, so an open jumper is harmless
    assign src_vec = {6'h00, mains_low_warning, src}; // R11 R12 R13 R14 R15
    always_comb
    begin
        for (int l = 0; l < LEVELS; l++)
            line[l] = src_vec[jumper_sel[l]]; // R1
    end

    assign mode = mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
    assign spacing8 = ctrl_q[CTRL_SPACING_BIT];
    assign base = {base_hi_q, base_lo_q};

    // Lowest level per mode; polled reuses fixed order
    always_comb
    begin
        case (mode)
            MODE_NESTED: lowest = NESTED_LOWEST; // R5
            MODE_AUTO: lowest = rot_low_q; // R6
            MODE_SPECIFIC: lowest = ctrl_q[CTRL_LOW_LSB +: 3]; // R7
            default: lowest = NESTED_LOWEST;
        endcase
    end

    // ------------------------------------------------------------
    // Priority resolution
    // ------------------------------------------------------------
    logic [LEVELS-1:0] pend;
    logic pend_found, isr_found;
    logic [2:0] pend_lvl, pend_rank, isr_lvl, isr_rank;
    logic outranks;

    assign pend = req_q & ~mask_q; // R4

    priority_resolver u_pend (
        .vec(pend),
        .lowest(lowest),
        .found(pend_found),
        .level(pend_lvl),
        .rank(pend_rank)
    );

    priority_resolver u_isr (
        .vec(inserv_q),
        .lowest(lowest),
        .found(isr_found),
        .level(isr_lvl),
        .rank(isr_rank)
    );

    assign outranks = pend_found && (!isr_found || pend_rank < isr_rank); // R3

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic ack, poll_ack, eoi;
    logic [LEVELS-1:0] req_clr, isr_set, isr_clr;
    logic [EV_W-1:0] ev_set, ev_clr;

    // One process for all registers but the edge detectors; set terms always win over clears
    always_comb
    begin
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        base_lo_d = base_lo_q;
        base_hi_d = base_hi_q;
        ev_mask_d = ev_mask_q;
        rot_low_d = rot_low_q;
        vec_d = '{valid: 1'b0, addr: vec_q.addr};
        rdata_d = 8'h00;
        req_clr = 8'h00;
        isr_set = 8'h00;
        isr_clr = 8'h00;
        ev_set = 3'h0;
        ev_clr = 3'h0;
        ack = inta && outranks && mode != MODE_POLLED;
        poll_ack = rd && addr == REG_POLL && mode == MODE_POLLED && pend_found;
        eoi = wr && addr == REG_EOI && isr_found;
        // Acknowledge: deliver vector, move level into service
        if (ack)
        begin
            req_clr = 8'h01 << pend_lvl; // R16
            isr_set = 8'h01 << pend_lvl; // R16
            vec_d = '{valid: 1'b1, addr: vector_of(base, pend_lvl, spacing8)}; // R9 R10
            ev_set[EV_VECTOR] = 1'b1;
        end
        else if (inta)
            ev_set[EV_SPURIOUS] = 1'b1;
        // Status read doubles as acknowledge while polled
        if (poll_ack)
        begin
            req_clr = 8'h01 << pend_lvl; // R8
            isr_set = 8'h01 << pend_lvl; // R8
        end
        // End of interrupt retires the top in-service level
        if (eoi)
        begin
            isr_clr = 8'h01 << isr_lvl; // R16
            if (mode == MODE_AUTO)
                rot_low_d = isr_lvl; // R6
        end
        if (pf_q == 1'b0 && mains_low_warning)
            ev_set[EV_POWER] = 1'b1; // R15
        // Register writes take effect on the next cycle, mode included
        if (wr)
        begin
            case (addr)
                REG_CTRL: ctrl_d = wdata; // R2
                REG_MASK: mask_d = wdata; // R4
                REG_BASE_LO: base_lo_d = wdata; // R10
                REG_BASE_HI: base_hi_d = wdata; // R10
                REG_EV_STAT: ev_clr = wdata[EV_W-1:0];
                REG_EV_MASK: ev_mask_d = wdata[EV_W-1:0];
                default: ;
            endcase
        end
        // Read data stands one cycle only; unmapped reads give zero
        if (rd)
        begin
            case (addr)
                REG_CTRL: rdata_d = ctrl_q;
                REG_MASK: rdata_d = mask_q;
                REG_BASE_LO: rdata_d = base_lo_q;
                REG_BASE_HI: rdata_d = base_hi_q;
                REG_REQ: rdata_d = req_q;
                REG_INSERV: rdata_d = inserv_q;
                REG_POLL: rdata_d = {pend_found, 4'h0, pend_lvl}; // R8
                REG_EV_STAT: rdata_d = {5'h00, ev_stat_q};
                REG_EV_MASK: rdata_d = {5'h00, ev_mask_q};
                default: rdata_d = 8'h00;
            endcase
        end
        // Rising edges latch requests, so a short pulse is not missed
        req_d = (req_q & ~req_clr) | (line & ~line_q); // R1
        inserv_d = (inserv_q & ~isr_clr) | isr_set;
        ev_stat_d = (ev_stat_q & ~ev_clr) | ev_set;
        cpu_int_d = outranks && mode != MODE_POLLED && !ack; // R3 R8
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Clock enable low freezes everything, including the edge detectors
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_q <= CTRL_RST;
            mask_q <= MASK_RST;
            base_lo_q <= BASE_RST;
            base_hi_q <= BASE_RST;
            req_q <= 8'h00;
            inserv_q <= 8'h00;
            line_q <= 8'h00;
            rot_low_q <= LOWEST_RST;
            ev_stat_q <= EV_RST;
            ev_mask_q <= EV_RST;
            pf_q <= 1'b0;
            cpu_int_q <= 1'b0;
            vec_q <= '{valid: 1'b0, addr: 16'h0000};
            rdata_q <= 8'h00;
        end
        else if (ce)
        begin
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            base_lo_q <= base_lo_d;
            base_hi_q <= base_hi_d;
            req_q <= req_d;
            inserv_q <= inserv_d;
            line_q <= line;
            rot_low_q <= rot_low_d;
            ev_stat_q <= ev_stat_d;
            ev_mask_q <= ev_mask_d;
            pf_q <= mains_low_warning;
            cpu_int_q <= cpu_int_d;
            vec_q <= vec_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;
    assign cpu_int = cpu_int_q;
    assign vector = vec_q;
    assign event_irq = |(ev_stat_q & ev_mask_q);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_POLLED_QUIET: assert property (@(posedge clk) disable iff (rst) // R8
        (ce && mode == MODE_POLLED) |=> !cpu_int_q)
        else $error("cpu interrupt raised in polled mode");

    AST_INT_NEEDS_UNMASKED: assert property (@(posedge clk) disable iff (rst) // R4
        ($rose(cpu_int_q) && $past(ce)) |-> |($past(req_q) & ~$past(mask_q)))
        else $error("cpu interrupt without unmasked request");

    AST_NO_INT_UNDER_SERVICE: assert property (@(posedge clk) disable iff (rst) // R3
        (ce && isr_found && pend_found && pend_rank >= isr_rank) |=> !cpu_int_q)
        else $error("interrupt raised for level not outranking service");

    AST_NESTED_ZERO_WINS: assert property (@(posedge clk) disable iff (rst) // R5
        (mode == MODE_NESTED && pend[0]) |-> (pend_found && pend_lvl == 3'h0))
        else $error("level 0 not highest in nested mode");

    AST_ROTATE_ON_EOI: assert property (@(posedge clk) disable iff (rst) // R6
        (ce && mode == MODE_AUTO && eoi) |=> rot_low_q == $past(isr_lvl))
        else $error("serviced level did not become lowest");

    AST_SPECIFIC_NEXT_WINS: assert property (@(posedge clk) disable iff (rst) // R7
        (mode == MODE_SPECIFIC && pend[3'(ctrl_q[CTRL_LOW_LSB +: 3] + 3'h1)])
        |-> pend_lvl == 3'(ctrl_q[CTRL_LOW_LSB +: 3] + 3'h1))
        else $error("level after named lowest did not win");

    AST_ACK_VECTOR: assert property (@(posedge clk) disable iff (rst) // R16
        (ce && ack) |=> (vector.valid && inserv_q[$past(pend_lvl)] && !req_q[$past(pend_lvl)]))
        else $error("acknowledge did not deliver vector and service level");

    AST_VECTOR_SPACING: assert property (@(posedge clk) disable iff (rst) // R9
        (ce && ack) |=> (vector.addr[4:2] == $past(pend_lvl) || vector.addr[5:3] == $past(pend_lvl))
        ##0 ($past(spacing8) ? vector.addr[2:0] == 3'h0 : vector.addr[1:0] == 2'h0))
        else $error("vector not spaced by four or eight bytes");

    AST_VECTOR_BASE: assert property (@(posedge clk) disable iff (rst) // R10
        (ce && ack) |=> vector.addr[15:6] == $past(base[15:6]))
        else $error("vector left its relocated table");

    AST_POWER_EVENT: assert property (@(posedge clk) disable iff (rst) // R15
        (ce && mains_low_warning && !pf_q) |=> ev_stat_q[EV_POWER])
        else $error("power fail event not recorded");

    COV_ACK: cover property (@(posedge clk) disable iff (rst) cpu_int_q ##1 ack ##1 vector.valid);
    COV_NESTED_INT: cover property (@(posedge clk) disable iff (rst) ack && isr_found);
    COV_POLL: cover property (@(posedge clk) disable iff (rst) poll_ack);
    COV_ROTATE: cover property (@(posedge clk) disable iff (rst) mode == MODE_AUTO && eoi);

endmodule

// [bench/host_cpu_model.sv]
// Host CPU model: answers the interrupt line with a one-cycle acknowledge pulse.
// Assumes the unit's cpu_int and vector outputs on the same clock.
`timescale 1ns/1ps

module host_cpu_model
    import priority_interrupt_unit_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cpu_int,
    input wire vec_out_t vector,
    input wire logic [3:0] delay,
    input wire logic spur,
    output logic inta,
    output logic [7:0] vec_count,
    output logic [15:0] last_addr
);
    logic [3:0] wait_cnt;
    logic [1:0] hold;

    // Acknowledge after a chosen delay; hold off a few cycles so one request gets one pulse
    always @(posedge clk)
    begin
        inta <= 1'b0;
        if (rst)
        begin
            wait_cnt <= 4'h0;
            hold <= 2'h0;
            vec_count <= 8'h00;
            last_addr <= 16'h0000;
        end
        else
        begin
            if (hold != 2'h0)
                hold <= hold - 2'h1;
            else if (spur || (cpu_int && wait_cnt >= delay))
            begin
                inta <= 1'b1;
                hold <= 2'h3;
                wait_cnt <= 4'h0;
            end
            else if (cpu_int)
                wait_cnt <= wait_cnt + 4'h1;
            if (vector.valid)
            begin
                vec_count <= vec_count + 8'h01;
                last_addr <= vector.addr;
            end
        end
    end
endmodule

// [bench/eight_level_vectored_interrupt_bench.sv]
// Self-checking bench of the priority interrupt unit with a host CPU model.
// Assumes the package register map and one 50 MHz clock.
`timescale 1ns/1ps

module eight_level_vectored_interrupt_bench
    import priority_interrupt_unit_pkg::*;
;
    logic clk, rst, ce, wr, rd, mains_low_warning, spur, inta, cpu_int, event_irq, sp8;
    logic [ADDR_W-1:0] addr, a_sel;
    logic [DATA_W-1:0] wdata, rdata, rv, exp_v;
    logic [24:0] src_bits;
    route_map_t jumper_sel, route;
    vec_out_t vector;
    logic [3:0] delay;
    logic [7:0] vec_count, seen_cnt;
    logic [15:0] last_addr, base;
    logic [2:0] low;
    int num_errors, num_checks;

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    priority_interrupt_unit u_priority_interrupt_unit (.clk(clk), .rst(rst), .ce(ce),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .src(src_lines_t'(src_bits)), .mains_low_warning(mains_low_warning),
        .jumper_sel(jumper_sel), .inta(inta), .cpu_int(cpu_int), .vector(vector),
        .event_irq(event_irq));

    host_cpu_model u_host_cpu_model (.clk(clk), .rst(rst), .cpu_int(cpu_int),
        .vector(vector), .delay(delay), .spur(spur), .inta(inta),
        .vec_count(vec_count), .last_addr(last_addr));

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        if (num_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask

    // Lines rise together for two cycles; requests latch on the rising edge
    task automatic drive(input logic [25:0] bits, input logic m);
        @(posedge clk);
        src_bits <= bits[24:0];
        mains_low_warning <= m;
        repeat (2) @(posedge clk);
        src_bits <= '0;
        mains_low_warning <= 1'b0;
    endtask

    function automatic logic [15:0] vaddr(input logic [2:0] l);
        return sp8 ? {base[15:6], l, 3'h0} : {base[15:5], l, 2'h0};
    endfunction

    // Bounded wait for the model to collect a new vector, then compare its address
    task automatic take_vec(input logic [2:0] l);
        int k;
        k = 0;
        while (vec_count === seen_cnt && k < 80)
        begin
            @(posedge clk);
            #1 k++;
        end
        if (k == 80)
        begin
            num_errors++;
            finish_test();
        end
        else
        begin
            seen_cnt = vec_count;
            check(last_addr, vaddr(l));
        end
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        {wr, rd, mains_low_warning, spur} = 4'h0;
        addr = '0;
        wdata = '0;
        src_bits = '0;
        delay = 4'h0;
        for (int l = 0; l < 8; l++)
            jumper_sel[l] = 5'(l);
        num_errors = 0;
        num_checks = 0;
        seen_cnt = 8'h00;
        void'($urandom(32'hf18e9af1));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // Reset values, unmapped places read zero
        for (int i = 0; i < 16; i++)
            if (i != 7)
            begin
                rd_reg(4'(i));
                check(rv, 8'h00);
            end
        check(cpu_int, 1'b0);
        // Read-write registers hold random values; read-only request register refuses
        for (int i = 0; i < 8; i++)
        begin
            exp_v = 8'($urandom);
            exp_v = (i == 0) ? exp_v & 8'h77 : (i > 3) ? exp_v & 8'h07 : exp_v;
            a_sel = (i < 4) ? 4'(i) : REG_EV_MASK;
            wr_reg(a_sel, exp_v);
            rd_reg(a_sel);
            check(rv, exp_v);
        end
        wr_reg(REG_REQ, 8'hFF);
        rd_reg(REG_REQ);
        check(rv, 8'h00);
        wr_reg(REG_MASK, 8'h00);
        // Clock enable low freezes the register port, so this write is lost
        ce <= 1'b0;
        wr_reg(REG_MASK, 8'hFF);
        ce <= 1'b1;
        rd_reg(REG_MASK);
        check(rv, 8'h00);
        wr_reg(REG_CTRL, 8'h03);
        // Every source routed in turn, served by polling
        for (int c = 0; c < 26; c++)
        begin
            for (int l = 0; l < 8; l++)
                route[l] = 5'h1F;
            route[c % 8] = 5'(c);
            jumper_sel <= route;
            drive((c == 25) ? 26'h0 : 26'h1 << c, c == 25);
            rd_reg(REG_POLL);
            check(rv, 8'h80 | 8'(c % 8));
            check(cpu_int, 1'b0);
            rd_reg(REG_INSERV);
            check(rv, 8'h01 << (c % 8));
            wr_reg(REG_EOI, 8'h00);
        end
        rd_reg(REG_EV_STAT);
        check(rv & 8'h04, 8'h04);
        wr_reg(REG_EV_STAT, 8'hFF);
        rd_reg(REG_EV_STAT);
        check(rv, 8'h00);
        for (int l = 0; l < 8; l++)
            route[l] = 5'(l);
        jumper_sel <= route;
        // Nested: relocated table, lower level waits for end of service
        base = 16'($urandom);
        sp8 = 1'($urandom);
        delay <= 4'($urandom % 8);
        wr_reg(REG_BASE_LO, base[7:0]);
        wr_reg(REG_BASE_HI, base[15:8]);
        wr_reg(REG_CTRL, {5'h0, sp8, 2'b00});
        wr_reg(REG_EV_MASK, 8'h01);
        drive(26'h24, 1'b0);
        take_vec(3'h2);
        check(event_irq, 1'b1);
        repeat (10) @(posedge clk);
        #1 check(vec_count, seen_cnt);
        wr_reg(REG_EOI, 8'h00);
        take_vec(3'h5);
        wr_reg(REG_EOI, 8'h00);
        // Masked level stays silent until unmasked
        wr_reg(REG_MASK, 8'h08);
        drive(26'h08, 1'b0);
        repeat (10) @(posedge clk);
        #1 check(cpu_int, 1'b0);
        wr_reg(REG_MASK, 8'h00);
        take_vec(3'h3);
        wr_reg(REG_EOI, 8'h00);
        // Specific: named lowest level, the rest in numeric sequence
        low = 3'($urandom);
        delay <= 4'($urandom % 16);
        wr_reg(REG_CTRL, {1'b0, low, 1'b0, sp8, 2'b10});
        drive(26'hFF, 1'b0);
        for (int i = 1; i < 9; i++)
        begin
            take_vec(3'(low + 3'(i)));
            wr_reg(REG_EOI, 8'h00);
        end
        // Auto rotation: a served level drops to lowest
        wr_reg(REG_CTRL, {5'h0, sp8, 2'b01});
        drive(26'h08, 1'b0);
        take_vec(3'h3);
        wr_reg(REG_EOI, 8'h00);
        drive(26'h28, 1'b0);
        take_vec(3'h5);
        wr_reg(REG_EOI, 8'h00);
        take_vec(3'h3);
        wr_reg(REG_EOI, 8'h00);
        // Acknowledge with nothing pending gives no vector and flags an event
        wr_reg(REG_EV_STAT, 8'hFF);
        wr_reg(REG_EV_MASK, 8'h02);
        spur <= 1'b1;
        @(posedge clk);
        spur <= 1'b0;
        repeat (4) @(posedge clk);
        #1 check(event_irq, 1'b1);
        check(vec_count, seen_cnt);
        rd_reg(REG_EV_STAT);
        check(rv, 8'h02);
        wr_reg(REG_EV_STAT, 8'h02);
        @(posedge clk);
        #1 check(event_irq, 1'b0);
        finish_test();
    end
endmodule
